// File: hdl/bt_timer.sv
// basic 16-bit timer: apb registers, trigger filter, prescaler, counter, flags
//
// Contract
// - filter trigger pin needing N equal samples; 000 bypasses, 001 is clock, two
// - codes 001, 010, 011 sample every clock needing two, four, six samples
// - 100 samples clock/4 six; 110 clock/16 four; 111 clock/16 six; 101 undefined
// - clock counting divides by divider value plus one
// - trigger-source counting divides by divider value; software keeps it nonzero
// - writable 16-bit reload limit sets overflow point, resets to all ones
// - live 16-bit counter readable and writable, resets to zero
// - top overflow raises interrupt only while enable bit 2 set
// - trigger event raises interrupt only while enable bit 1 set
// - reload overflow raises interrupt only while enable bit 0 set
// - status bit 2 set on top overflow, held until cleared
// - status bit 1 set on trigger event
// - status bit 0 set on reload overflow
// - writing zero to clear bits clears flags; one does nothing; reads ones
// - dma enable bit 1 requests dma when trigger starts the counter
// - dma enable bit 0 requests dma on each reload overflow
// - mode 01 counts edges of selected trigger source instead of clock
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "bt_map.svh"

module bt_timer
   import bt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // trigger inputs
   input wire logic ext_trigger_i,
   input wire logic int_trigger_i,
   // requests
   output logic irq_o,
   output logic dma_trigger_o,
   output logic dma_overflow_o
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0] reload_limit_q;
   logic [15:0] counter_value_q;
   logic [15:0] divider_value_q;
   logic [15:0] div_cnt_q;
   bt_flt_t trigger_filter_select_q;
   logic [5:0] ctrl_q;
   logic [2:0] irq_en_q;
   logic [2:0] flags_q;
   logic [1:0] dma_en_q;
   logic started_q;
   logic trig_prev_q;
   logic pin_s1_q;
   logic pin_s2_q;
   logic flt_cand_q;
   logic [2:0] flt_run_q;
   logic flt_level_q;
   logic [3:0] smp_div_q;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic setup;
   logic wr_acc;
   logic sel_reload;
   logic sel_count;
   logic sel_flt;
   logic sel_ctrl;
   logic sel_ien;
   logic sel_flags;
   logic sel_clr;
   logic sel_dma;
   logic sel_div;
   logic mapped;
   logic [31:0] rd_data;

   // address match, access phase write strobe
   assign setup = psel_i & ~penable_i;
   assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;
   assign sel_reload = paddr_i == `BT_OFF_RELOAD;
   assign sel_count = paddr_i == `BT_OFF_COUNT;
   assign sel_flt = paddr_i == `BT_OFF_TRIG_FLT;
   assign sel_ctrl = paddr_i == `BT_OFF_CTRL;
   assign sel_ien = paddr_i == `BT_OFF_IRQ_EN;
   assign sel_flags = paddr_i == `BT_OFF_IRQ_FLAGS;
   assign sel_clr = paddr_i == `BT_OFF_IRQ_CLR;
   assign sel_dma = paddr_i == `BT_OFF_DMA_EN;
   assign sel_div = paddr_i == `BT_OFF_DIVIDER;
   assign mapped = sel_reload | sel_count | sel_flt | sel_ctrl | sel_ien
      | sel_flags | sel_clr | sel_dma | sel_div;

   // read mux, unused bits read zero
   assign rd_data =
      sel_reload ? {16'h0000, reload_limit_q} :
      sel_count ? {16'h0000, counter_value_q} :
      sel_flt ? {25'h0, trigger_filter_select_q, 4'h0} :
      sel_ctrl ? {26'h0, ctrl_q} :
      sel_ien ? {29'h0, irq_en_q} :
      sel_flags ? {29'h0, flags_q} :
      sel_clr ? {29'h0, `BT_RST_CLR_READ} :
      sel_dma ? {30'h0, dma_en_q} :
      sel_div ? {16'h0000, divider_value_q} :
      32'h00000000;

   // answer registered in setup, zero wait states
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
      end else begin
         pready_o <= setup;
         pslverr_o <= setup & ~mapped;
         prdata_o <= (setup & ~pwrite_i) ? rd_data : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   bt_mode_e mode;
   logic en;
   logic pol;
   logic oneshot;

   assign mode = bt_mode_e'(ctrl_q[`BT_CTRL_MODE_MSB:`BT_CTRL_MODE_LSB]);
   assign en = ctrl_q[`BT_CTRL_EN];
   assign pol = ctrl_q[`BT_CTRL_POL];
   assign oneshot = ctrl_q[`BT_CTRL_ONESHOT];

   // ----------------------------------------------------------------
   // trigger pin synchroniser and filter
   // ----------------------------------------------------------------
   logic smp_en;
   logic [2:0] need_n;
   logic bypass;
   logic same;
   logic [2:0] run_d;
   logic cand_d;

   // sample rate from filter code, 101 treated as bypass
   assign bypass = (trigger_filter_select_q == 3'h0)
      | (trigger_filter_select_q == 3'h5);
   assign smp_en = ~trigger_filter_select_q[2] ? 1'b1 :
      trigger_filter_select_q[1] ? (smp_div_q == `BT_FLT_DIV16_LAST) :
      ((smp_div_q & `BT_FLT_DIV4_MASK) == `BT_FLT_DIV4_LAST);
   assign need_n =
      (trigger_filter_select_q == 3'h1) ? `BT_FLT_N2 :
      (trigger_filter_select_q == 3'h2) ? `BT_FLT_N4 :
      (trigger_filter_select_q == 3'h6) ? `BT_FLT_N4 :
      `BT_FLT_N6;
   assign same = pin_s2_q == flt_cand_q;
   assign cand_d = pin_s2_q;
   assign run_d = same ? ((flt_run_q == `BT_FLT_N6) ? flt_run_q : flt_run_q + 3'h1)
      : 3'h1;

   // two flops, then equal-sample counter
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         smp_div_q <= 4'h0;
         flt_cand_q <= 1'b0;
         flt_run_q <= 3'h0;
         flt_level_q <= 1'b0;
      end else begin
         pin_s1_q <= ext_trigger_i;
         pin_s2_q <= pin_s1_q;
         smp_div_q <= smp_div_q + 4'h1;
         if (bypass) begin
            flt_level_q <= pin_s2_q;
            flt_cand_q <= pin_s2_q;
            flt_run_q <= 3'h1;
         end else if (smp_en) begin
            flt_cand_q <= cand_d;
            flt_run_q <= run_d;
            if (run_d >= need_n) begin
               flt_level_q <= cand_d;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // trigger edge, gate, start
   // ----------------------------------------------------------------
   logic trig_lvl;
   logic trig_edge;
   logic gate_on;
   logic trig_evt;
   logic start_evt;
   logic running;

   assign trig_lvl = (ctrl_q[`BT_CTRL_SRC] ? int_trigger_i : flt_level_q) ^ pol;
   assign trig_edge = trig_lvl & ~trig_prev_q;
   assign gate_on = flt_level_q ^ pol;
   assign trig_evt = en & trig_edge;
   assign start_evt = trig_evt & (mode == BT_MODE_TRIG) & ~started_q;
   assign running = en & ((mode == BT_MODE_TIMER) | (mode == BT_MODE_COUNTER)
      | ((mode == BT_MODE_TRIG) & started_q) | ((mode == BT_MODE_GATED) & gate_on));

   // ----------------------------------------------------------------
   // prescaler and counter
   // ----------------------------------------------------------------
   logic src_tick;
   logic [15:0] div_lim;
   logic div_hit;
   logic cnt_tick;
   logic wrap_evt;
   logic top_evt;
   logic [15:0] cnt_d;

   // counter mode ticks on source edges, others on every clock
   always_comb begin
      unique case (mode)
         BT_MODE_COUNTER: src_tick = trig_edge;
         BT_MODE_TIMER,
         BT_MODE_TRIG,
         BT_MODE_GATED: src_tick = 1'b1;
      endcase
   end
   assign div_lim = (mode == BT_MODE_COUNTER)
      ? ((divider_value_q == 16'h0000) ? 16'h0000 : divider_value_q - 16'h0001)
      : divider_value_q;
   assign div_hit = src_tick & (div_cnt_q == div_lim);
   assign cnt_tick = running & div_hit;
   assign wrap_evt = cnt_tick & (counter_value_q == reload_limit_q);
   assign top_evt = cnt_tick & (counter_value_q == 16'hffff);
   assign cnt_d = (wr_acc & sel_count) ? pwdata_i[15:0] :
      wrap_evt ? 16'h0000 :
      cnt_tick ? counter_value_q + 16'h0001 : counter_value_q;

   // divider count, counter and start state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt_q <= 16'h0000;
         counter_value_q <= `BT_RST_COUNT;
         started_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         trig_prev_q <= trig_lvl;
         counter_value_q <= cnt_d;
         if (!running) begin
            div_cnt_q <= 16'h0000;
         end else if (src_tick) begin
            div_cnt_q <= div_hit ? 16'h0000 : div_cnt_q + 16'h0001;
         end
         if (!en || (wrap_evt && oneshot)) begin
            started_q <= 1'b0;
         end else if (start_evt) begin
            started_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   logic [2:0] flag_set;
   logic [2:0] flag_clr;

   assign flag_set = {top_evt, trig_evt, wrap_evt};
   assign flag_clr = (wr_acc & sel_clr) ? ~pwdata_i[2:0] : 3'h0;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reload_limit_q <= `BT_RST_RELOAD;
         divider_value_q <= `BT_RST_DIVIDER;
         trigger_filter_select_q <= 3'h0;
         ctrl_q <= 6'h00;
         irq_en_q <= 3'h0;
         dma_en_q <= 2'h0;
         flags_q <= 3'h0;
      end else begin
         if (wr_acc && sel_reload) begin
            reload_limit_q <= pwdata_i[15:0];
         end
         if (wr_acc && sel_div) begin
            divider_value_q <= pwdata_i[15:0];
         end
         if (wr_acc && sel_flt) begin
            trigger_filter_select_q <= pwdata_i[`BT_FLT_MSB:`BT_FLT_LSB];
         end
         if (wr_acc && sel_ctrl) begin
            ctrl_q <= pwdata_i[5:0];
         end else if (wrap_evt && oneshot) begin
            ctrl_q[`BT_CTRL_EN] <= 1'b0;
         end
         if (wr_acc && sel_ien) begin
            irq_en_q <= pwdata_i[2:0];
         end
         if (wr_acc && sel_dma) begin
            dma_en_q <= pwdata_i[1:0];
         end
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   // ----------------------------------------------------------------
   // interrupt and dma requests
   // ----------------------------------------------------------------
   logic irq_d;

   assign irq_d = |(flags_q & irq_en_q);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         dma_trigger_o <= 1'b0;
         dma_overflow_o <= 1'b0;
      end else begin
         irq_o <= irq_d;
         dma_trigger_o <= start_evt & dma_en_q[`BT_DMA_START];
         dma_overflow_o <= wrap_evt & dma_en_q[`BT_DMA_WRAP];
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_irq_top_gate: assert property (
      flags_q[`BT_FLAG_TOP] && irq_en_q[2] |=> irq_o)
      else $error("top flag enabled but no interrupt");
   a_irq_masked: assert property (
      (flags_q & irq_en_q) == 3'h0 |=> !irq_o)
      else $error("interrupt without enabled flag");
   a_top_flag_set: assert property (
      top_evt |=> flags_q[`BT_FLAG_TOP])
      else $error("top flag not set");
   a_trig_flag_set: assert property (
      trig_evt |=> flags_q[`BT_FLAG_TRIG] ##1 irq_o || !irq_en_q[1])
      else $error("trigger flag not set");
   a_wrap_flag_set: assert property (
      wrap_evt |=> flags_q[`BT_FLAG_WRAP] && counter_value_q == 16'h0000 || $past(wr_acc))
      else $error("overflow flag or wrap missing");
   a_flag_sticky: assert property (
      flags_q[0] && !(wr_acc && sel_clr && !pwdata_i[0]) |=> flags_q[0])
      else $error("flag lost without clear");
   a_dma_wrap_pulse: assert property (
      dma_overflow_o |-> $past(wrap_evt) && $past(dma_en_q[0]) ##1 !dma_overflow_o
      || $past(wrap_evt, 1) && wrap_evt)
      else $error("dma overflow request not tied to overflow");
   a_dma_start_pulse: assert property (
      start_evt && dma_en_q[1] |=> dma_trigger_o && started_q)
      else $error("dma trigger request missing at start");
   // two equal samples in a row must stand behind every filtered change while code 001 is selected
   a_filter_two: assert property (
      trigger_filter_select_q == 3'h1 && $past(trigger_filter_select_q) == 3'h1
      && $past(trigger_filter_select_q, 2) == 3'h1 && $changed(flt_level_q)
      |-> $past(pin_s2_q) == flt_level_q && $past(pin_s2_q, 2) == flt_level_q)
      else $error("filter passed single sample");
   c_overflow: cover property (wrap_evt ##[1:20] wrap_evt);
   c_trig_start: cover property (start_evt ##1 dma_trigger_o);
   c_slow_filter: cover property (trigger_filter_select_q == 3'h7 && $changed(flt_level_q));
   c_gated_run: cover property (mode == BT_MODE_GATED && cnt_tick);
   c_oneshot_stop: cover property (wrap_evt && oneshot ##1 !en);

endmodule

// File: hdl/bt_map.svh
// register offsets, field positions, reset values and counts of the basic timer
`ifndef BT_MAP_SVH
`define BT_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BT_OFF_RELOAD 8'h00
`define BT_OFF_COUNT 8'h04
`define BT_OFF_TRIG_FLT 8'h0c
`define BT_OFF_CTRL 8'h10
`define BT_OFF_IRQ_EN 8'h14
`define BT_OFF_IRQ_FLAGS 8'h18
`define BT_OFF_IRQ_CLR 8'h1c
`define BT_OFF_DMA_EN 8'h20
`define BT_OFF_DIVIDER 8'h24
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BT_RST_RELOAD 16'hffff
`define BT_RST_COUNT 16'h0000
`define BT_RST_DIVIDER 16'h0000
`define BT_RST_CLR_READ 3'h7
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BT_FLT_LSB 4
`define BT_FLT_MSB 6
`define BT_CTRL_EN 0
`define BT_CTRL_MODE_LSB 1
`define BT_CTRL_MODE_MSB 2
`define BT_CTRL_SRC 3
`define BT_CTRL_POL 4
`define BT_CTRL_ONESHOT 5
`define BT_FLAG_WRAP 0
`define BT_FLAG_TRIG 1
`define BT_FLAG_TOP 2
`define BT_DMA_WRAP 0
`define BT_DMA_START 1
// ----------------------------------------------------------------
// filter sample counts and sample dividers
// ----------------------------------------------------------------
`define BT_FLT_N2 3'h2
`define BT_FLT_N4 3'h4
`define BT_FLT_N6 3'h6
`define BT_FLT_DIV4_LAST 4'h3
`define BT_FLT_DIV4_MASK 4'h3
`define BT_FLT_DIV16_LAST 4'hf
`endif

// File: hdl/bt_pkg.sv
// types shared by the basic timer register bank
package bt_pkg;
   // counting modes in field order
   typedef enum logic [1:0] {
      BT_MODE_TIMER,
      BT_MODE_COUNTER,
      BT_MODE_TRIG,
      BT_MODE_GATED
   } bt_mode_e;
   // trigger filter selection codes
   typedef logic [2:0] bt_flt_t;
endpackage

// File: tb/bt_trig_src.sv
// trigger pin source model for the basic timer bench
`timescale 1ns/1ps

module bt_trig_src (
   // clock
   input wire logic clk_i,
   // trigger pin
   output logic pin_o
);
   // idle level is low; a pulse of n clocks starts just after an edge
   initial begin
      pin_o = 1'b0;
   end

   task automatic pulse(input int n);
      @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      pin_o <= 1'b0;
   endtask
endmodule

// File: tb/bt_timer_tb.sv
// self-checking bench for the basic timer register bank
`timescale 1ns/1ps
`include "bt_map.svh"

module bt_timer_tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_i, rst_i, psel_i, penable_i, pwrite_i, int_trigger_i, ext_trigger_i;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic pready_o, pslverr_o, irq_o, dma_trigger_o, dma_overflow_o;
   int error_cnt, samples_checked, cyc, wrap_cnt, tg_cnt, t_last, t_prev;

   bt_timer dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_trigger_i(ext_trigger_i),
      .int_trigger_i(int_trigger_i), .irq_o(irq_o), .dma_trigger_o(dma_trigger_o),
      .dma_overflow_o(dma_overflow_o));

   bt_trig_src src (.clk_i(clk_i), .pin_o(ext_trigger_i));

   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // pulse counters, overflow stamps and hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (dma_overflow_o === 1'b1) begin
         wrap_cnt <= wrap_cnt + 1;
         t_prev <= t_last;
         t_last <= cyc;
      end
      if (dma_trigger_o === 1'b1) tg_cnt <= tg_cnt + 1;
      if (cyc == 30000) begin
         error_cnt++;
         stop_test();
      end
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      chk("wait states", n, 32'd1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, r, exp);
   endtask

   // n rising edges on the internal trigger source
   task automatic edges(input int n);
      repeat (n) begin
         @(posedge clk_i);
         int_trigger_i <= 1'b1;
         repeat (2) @(posedge clk_i);
         int_trigger_i <= 1'b0;
         @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rd(`BT_OFF_RELOAD, 32'h0000ffff, "reload");
      rd(`BT_OFF_COUNT, 32'h0, "count");
      rd(`BT_OFF_IRQ_CLR, 32'h7, "clear");
      rd(`BT_OFF_IRQ_FLAGS, 32'h0, "flags");
      rd(`BT_OFF_IRQ_EN, 32'h0, "irq_en");
      rd(`BT_OFF_DMA_EN, 32'h0, "dma_en");
      rd(`BT_OFF_DIVIDER, 32'h0, "divider");
      rd(`BT_OFF_TRIG_FLT, 32'h0, "filter");
      apb(1'b0, 8'h08, 32'h0, r, e);
      chk("unmapped", {31'h0, e}, 32'h1);
      wr(`BT_OFF_RELOAD, 32'h00001234);
      rd(`BT_OFF_RELOAD, 32'h1234, "reload wr");
      wr(`BT_OFF_COUNT, 32'h0000abcd);
      rd(`BT_OFF_COUNT, 32'habcd, "count wr");
      wr(`BT_OFF_IRQ_FLAGS, 32'h7);
      rd(`BT_OFF_IRQ_FLAGS, 32'h0, "flags ro");
      $display("test reset done");
   endtask

   task automatic t_overflow();
      wr(`BT_OFF_RELOAD, 32'h3);
      wr(`BT_OFF_COUNT, 32'h0);
      wr(`BT_OFF_DIVIDER, 32'h1);
      wr(`BT_OFF_IRQ_EN, 32'h1);
      wr(`BT_OFF_DMA_EN, 32'h1);
      wr(`BT_OFF_CTRL, 32'h1);
      repeat (40) @(posedge clk_i);
      wr(`BT_OFF_CTRL, 32'h0);
      chk("wrap period", t_last - t_prev, 32'd8);
      chk("wrap irq", {31'h0, irq_o}, 32'h1);
      rd(`BT_OFF_IRQ_FLAGS, 32'h1, "wrap flag");
      wr(`BT_OFF_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("wrap mask", {31'h0, irq_o}, 32'h0);
      wr(`BT_OFF_IRQ_CLR, 32'h7);
      rd(`BT_OFF_IRQ_FLAGS, 32'h1, "wrap sticky");
      wr(`BT_OFF_IRQ_CLR, 32'h6);
      rd(`BT_OFF_IRQ_FLAGS, 32'h0, "wrap clear");
      $display("test overflow done");
   endtask

   task automatic t_top();
      int n0;
      n0 = wrap_cnt;
      wr(`BT_OFF_DMA_EN, 32'h0);
      wr(`BT_OFF_RELOAD, 32'hffff);
      wr(`BT_OFF_DIVIDER, 32'h0);
      wr(`BT_OFF_COUNT, 32'hfff8);
      wr(`BT_OFF_IRQ_EN, 32'h4);
      wr(`BT_OFF_CTRL, 32'h1);
      repeat (20) @(posedge clk_i);
      wr(`BT_OFF_CTRL, 32'h0);
      chk("top irq", {31'h0, irq_o}, 32'h1);
      chk("no dma", wrap_cnt - n0, 32'h0);
      wr(`BT_OFF_IRQ_CLR, 32'h4);
      rd(`BT_OFF_IRQ_FLAGS, 32'h4, "top flag");
      wr(`BT_OFF_IRQ_CLR, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("top irq off", {31'h0, irq_o}, 32'h0);
      $display("test top done");
   endtask

   task automatic t_filter();
      logic [2:0] code [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
      int sh [7] = '{0, 1, 3, 5, 3, 3, 3};
      wr(`BT_OFF_COUNT, 32'h0);
      wr(`BT_OFF_IRQ_EN, 32'h2);
      wr(`BT_OFF_CTRL, 32'h1);
      for (int i = 0; i < 7; i++) begin
         wr(`BT_OFF_TRIG_FLT, {25'h0, code[i], 4'h0});
         wr(`BT_OFF_IRQ_CLR, 32'h0);
         if (sh[i] > 0) begin
            src.pulse(sh[i]);
            repeat (130) @(posedge clk_i);
            rd(`BT_OFF_IRQ_FLAGS, 32'h0, "short pulse");
            chk("short irq", {31'h0, irq_o}, 32'h0);
         end
         src.pulse(120);
         repeat (130) @(posedge clk_i);
         rd(`BT_OFF_IRQ_FLAGS, 32'h2, "long pulse");
         chk("long irq", {31'h0, irq_o}, 32'h1);
      end
      wr(`BT_OFF_CTRL, 32'h0);
      wr(`BT_OFF_IRQ_CLR, 32'h0);
      $display("test filter done");
   endtask

   task automatic t_counter();
      wr(`BT_OFF_COUNT, 32'h0);
      wr(`BT_OFF_DIVIDER, 32'h2);
      wr(`BT_OFF_CTRL, 32'hb);
      edges(6);
      wr(`BT_OFF_CTRL, 32'h0);
      rd(`BT_OFF_COUNT, 32'h3, "count div2");
      wr(`BT_OFF_COUNT, 32'h0);
      wr(`BT_OFF_DIVIDER, 32'h1);
      wr(`BT_OFF_CTRL, 32'hb);
      edges(4);
      wr(`BT_OFF_CTRL, 32'h0);
      rd(`BT_OFF_COUNT, 32'h4, "count div1");
      $display("test counter done");
   endtask

   task automatic t_start();
      int n0;
      wr(`BT_OFF_COUNT, 32'h0);
      wr(`BT_OFF_IRQ_CLR, 32'h0);
      wr(`BT_OFF_DIVIDER, 32'h0);
      wr(`BT_OFF_DMA_EN, 32'h2);
      n0 = tg_cnt;
      wr(`BT_OFF_CTRL, 32'hd);
      repeat (10) @(posedge clk_i);
      chk("no start", tg_cnt - n0, 32'h0);
      rd(`BT_OFF_COUNT, 32'h0, "held");
      edges(1);
      chk("dma start", tg_cnt - n0, 32'h1);
      rd(`BT_OFF_IRQ_FLAGS, 32'h2, "trig flag");
      wr(`BT_OFF_CTRL, 32'h0);
      $display("test start done");
   endtask

   // gated counting on the pin, then a one-shot run that stops itself
   task automatic t_modes();
      wr(`BT_OFF_TRIG_FLT, 32'h0);
      wr(`BT_OFF_COUNT, 32'h0);
      wr(`BT_OFF_CTRL, 32'h7);
      repeat (10) @(posedge clk_i);
      src.pulse(20);
      repeat (10) @(posedge clk_i);
      wr(`BT_OFF_CTRL, 32'h0);
      rd(`BT_OFF_COUNT, 32'h14, "gated count");
      wr(`BT_OFF_RELOAD, 32'h3);
      wr(`BT_OFF_COUNT, 32'h0);
      wr(`BT_OFF_IRQ_CLR, 32'h0);
      wr(`BT_OFF_CTRL, 32'h21);
      repeat (20) @(posedge clk_i);
      rd(`BT_OFF_CTRL, 32'h20, "oneshot stop");
      rd(`BT_OFF_COUNT, 32'h0, "oneshot count");
      rd(`BT_OFF_IRQ_FLAGS, 32'h1, "oneshot flag");
      $display("test modes done");
   endtask

   // ----------------------------------------
   // verdict and main sequence
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      error_cnt = 0;
      samples_checked = 0;
      cyc = 0;
      wrap_cnt = 0;
      tg_cnt = 0;
      t_last = 0;
      t_prev = 0;
      rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      int_trigger_i = 1'b0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_overflow();
      t_top();
      t_filter();
      t_counter();
      t_start();
      t_modes();
      stop_test();
   end
endmodule
